/* File: hdl/rmps_regs.svh */
// Timing counts and delivery defaults for the radio module power sequencer.
// Assumes a single 50 MHz clock shared by host and module ends.
//
// ****************************************************************
// Overview of operation
// R1 - Host waits over 50 us before enable
// R2 - Enable pin switches internal regulators on
// R3 - Host applies IO supply within 18 ms
// R4 - Host keeps IO quiet until settled
// R5 - Host quiets IO before power-down
// R6 - Module releases IO drive within 300 us
// R7 - Enable off, wait 300 us, drop supply
// R8 - CTS and RTS modes, defaults as delivered
// R9 - Error check: none or three CRCs
// R10 - Radio state Tx/Rx or Rx only
// R11 - Serial port defaults 115200 8N1
// ****************************************************************
`ifndef RMPS_REGS_SVH
`define RMPS_REGS_SVH

// Clock
`define RMPS_CLK_HZ        50000000
`define RMPS_CLK_PERIOD_NS 20

// Intervals in their own units
`define RMPS_T_VIC_NS      50000
`define RMPS_T_IOEN_NS     18000000
`define RMPS_T_IOVS_NS     1000000
`define RMPS_T_IOR_NS      300000
`define RMPS_T_LDOF_NS     300000

// Cycle counts: least times round up past the bound (IOVS settle held exact), longest round down
`define RMPS_VIC_CYC  (`RMPS_T_VIC_NS / `RMPS_CLK_PERIOD_NS + 1)
`define RMPS_IOEN_CYC (`RMPS_T_IOEN_NS / `RMPS_CLK_PERIOD_NS - 1)
`define RMPS_IOVS_CYC (`RMPS_T_IOVS_NS / `RMPS_CLK_PERIOD_NS)
`define RMPS_IOR_CYC  (`RMPS_T_IOR_NS / `RMPS_CLK_PERIOD_NS - 1)
`define RMPS_LDOF_CYC (`RMPS_T_LDOF_NS / `RMPS_CLK_PERIOD_NS + 1)

// Delivery defaults of the settings
`define RMPS_DEF_CTS    1'h1
`define RMPS_DEF_RTS    1'h0
`define RMPS_DEF_ERR    2'h0
`define RMPS_DEF_RADIO  1'h0
`define RMPS_DEF_PARITY 2'h0
`define RMPS_DEF_BAUD   3'h7

`endif

/* File: hdl/rmps_pkg.sv */
// Types shared by both ends of the radio module power sequencer.
// Assumes rmps_regs.svh supplies the numeric constants.
package rmps_pkg;
  typedef enum logic [0:0] {RMPS_CTS_CLEAR, RMPS_CTS_TXBUF} rmps_cts_t;
  typedef enum logic [0:0] {RMPS_RTS_IGNORED, RMPS_RTS_FLOW} rmps_rts_t;
  typedef enum logic [1:0] {RMPS_ERR_NONE, RMPS_ERR_CRC_BYTE_PARTIAL,
                            RMPS_ERR_CRC_BYTE_FULL, RMPS_ERR_CRC_WORD_FULL} rmps_err_t;
  typedef enum logic [0:0] {RMPS_RADIO_TXRX, RMPS_RADIO_RX} rmps_radio_t;
  typedef enum logic [1:0] {RMPS_PAR_NONE, RMPS_PAR_EVEN, RMPS_PAR_ODD,
                            RMPS_PAR_RSVD} rmps_par_t;
  typedef enum logic [2:0] {RMPS_B1200, RMPS_B2400, RMPS_B4800, RMPS_B9600,
                            RMPS_B19200, RMPS_B38400, RMPS_B57600,
                            RMPS_B115200} rmps_baud_t;
  typedef enum {DEV_OFF, DEV_WAIT_IO, DEV_RUN, DEV_FALL} rmps_dev_st_t;
  typedef enum {HST_OFF, HST_CHARGE, HST_IO_START, HST_SETTLE, HST_READY,
                HST_QUIET, HST_DISCHARGE} rmps_hst_st_t;
endpackage

/* File: hdl/rmps_if.sv */
// Link between host controller and radio module: supplies, enable, IO lines.
// Assumes both ends share one clock; the bench resolves wire levels.
`timescale 1ns/1ps
interface rmps_if;
  logic vcc_in_on;         // Host: main supply switched on
  logic vcc_io_on;         // Host: IO supply switched on
  logic module_enable_pin; // Host: module enable
  logic txd;               // Host to module data
  logic txd_oe;
  logic rts;               // Host to module handshake
  logic rts_oe;
  logic rxd;               // Module to host data
  logic rxd_oe;
  logic cts;               // Module to host handshake
  logic cts_oe;

  modport host (output vcc_in_on, vcc_io_on, module_enable_pin, txd, txd_oe,
                rts, rts_oe, input rxd, rxd_oe, cts, cts_oe);
  modport module_end (input vcc_in_on, vcc_io_on, module_enable_pin, txd,
                      txd_oe, rts, rts_oe, output rxd, rxd_oe, cts, cts_oe);
endinterface

/* File: hdl/rmps_module.sv */
// Module end: regulators, IO drive release and configurable port settings.
// Assumes link pins arrive unsynchronised; user side runs on clk.
`timescale 1ns/1ps
`include "rmps_regs.svh"
module rmps_module
  import rmps_pkg::*;
#(
  parameter int unsigned FALL_CYC = `RMPS_IOR_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Link
  rmps_if.module_end       link,
  // Setting writes
  input  wire logic        cfg_we,
  input  wire rmps_cts_t   cfg_cts,
  input  wire rmps_rts_t   cfg_rts,
  input  wire rmps_err_t   cfg_err,
  input  wire rmps_radio_t cfg_radio,
  input  wire rmps_par_t   cfg_parity,
  input  wire rmps_baud_t  cfg_baud,
  // Current settings
  output rmps_cts_t        cur_cts_q,
  output rmps_rts_t        cur_rts_q,
  output rmps_err_t        cur_err_q,
  output rmps_radio_t      cur_radio_q,
  output rmps_par_t        cur_parity_q,
  output rmps_baud_t       cur_baud_q,
  output logic [15:0]      baud_div_q,
  // Module status
  output logic             regulators_on_q,
  output logic             running_q,
  output logic             tx_enable_q,
  output logic             tx_allow_q,
  // Data path
  input  wire logic        user_rxd,
  input  wire logic        rx_ready,
  input  wire logic        tx_buf_full,
  output logic             user_txd_q
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] pins;
  logic       en_s;
  logic       io_s;
  logic       txd_s;
  logic       rts_s;

  // Enable and IO supply are sensed through the IO domain as well
  assign pins  = {link.module_enable_pin, link.vcc_io_on & link.vcc_in_on,
                  link.txd & link.txd_oe, link.rts & link.rts_oe};
  assign en_s  = sync2_q[3];
  assign io_s  = sync2_q[2];
  assign txd_s = sync2_q[1];
  assign rts_s = sync2_q[0];

  // Two flip-flops per pin
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************************************
  // Power state
  // ****************************************************************
  rmps_dev_st_t st_q;
  rmps_dev_st_t st_d;
  logic [19:0]  cnt_q;
  logic [19:0]  cnt_d;
  logic         drive_d;
  logic         drive_q;

  // Next power state and IO drive
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    drive_d = 1'h0;
    case (st_q)
      DEV_OFF: begin
        cnt_d = 20'h0;
        if (en_s) begin
          st_d = DEV_WAIT_IO; // R2
        end
      end
      DEV_WAIT_IO: begin
        if (!en_s) begin
          st_d = DEV_OFF;
        end else if (io_s) begin
          st_d = DEV_RUN;
        end
      end
      DEV_RUN: begin
        drive_d = 1'h1;
        cnt_d   = 20'h0;
        if (!en_s || !io_s) begin
          st_d = DEV_FALL;
        end
      end
      DEV_FALL: begin
        // Pins held low, then released before the fall bound
        drive_d = 1'h0;
        cnt_d   = cnt_q + 20'h1;
        if (cnt_q >= 20'(FALL_CYC - 1)) begin
          st_d = DEV_OFF; // R6
        end
      end
      default: begin
        st_d = DEV_OFF;
      end
    endcase
  end

  // Power state registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q    <= DEV_OFF;
      cnt_q   <= 20'h0;
      drive_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      drive_q <= drive_d;
    end
  end

  // ****************************************************************
  // Settings
  // ****************************************************************
  rmps_cts_t   cts_d;
  rmps_rts_t   rts_d;
  rmps_err_t   err_d;
  rmps_radio_t radio_d;
  rmps_par_t   par_d;
  rmps_baud_t  baud_d;
  logic [15:0] div_d;
  int unsigned rate;

  // Setting writes; reserved parity code keeps the old value
  always_comb begin
    cts_d   = cur_cts_q;
    rts_d   = cur_rts_q;
    err_d   = cur_err_q;
    radio_d = cur_radio_q;
    par_d   = cur_parity_q;
    baud_d  = cur_baud_q;
    if (cfg_we) begin
      cts_d   = cfg_cts;   // R8
      rts_d   = cfg_rts;   // R8
      err_d   = cfg_err;   // R9
      radio_d = cfg_radio; // R10
      baud_d  = cfg_baud;  // R11
      if (cfg_parity != RMPS_PAR_RSVD) begin
        par_d = cfg_parity;
      end
    end
    case (baud_d)
      RMPS_B1200:  rate = 1200;
      RMPS_B2400:  rate = 2400;
      RMPS_B4800:  rate = 4800;
      RMPS_B9600:  rate = 9600;
      RMPS_B19200: rate = 19200;
      RMPS_B38400: rate = 38400;
      RMPS_B57600: rate = 57600;
      default:     rate = 115200;
    endcase
    div_d = 16'(`RMPS_CLK_HZ / rate); // R11
  end

  // Settings come up at delivery defaults
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cur_cts_q    <= rmps_cts_t'(`RMPS_DEF_CTS);      // R8
      cur_rts_q    <= rmps_rts_t'(`RMPS_DEF_RTS);      // R8
      cur_err_q    <= rmps_err_t'(`RMPS_DEF_ERR);      // R9
      cur_radio_q  <= rmps_radio_t'(`RMPS_DEF_RADIO);  // R10
      cur_parity_q <= rmps_par_t'(`RMPS_DEF_PARITY);   // R11
      cur_baud_q   <= rmps_baud_t'(`RMPS_DEF_BAUD);    // R11
      baud_div_q   <= 16'(`RMPS_CLK_HZ / 115200);
    end else begin
      cur_cts_q    <= cts_d;
      cur_rts_q    <= rts_d;
      cur_err_q    <= err_d;
      cur_radio_q  <= radio_d;
      cur_parity_q <= par_d;
      cur_baud_q   <= baud_d;
      baud_div_q   <= div_d;
    end
  end

  // ****************************************************************
  // Outputs and handshake
  // ****************************************************************
  logic cts_val;
  logic run_d;

  assign run_d   = (st_d == DEV_RUN);
  // CTS shows either receive readiness or transmit buffer room
  assign cts_val = (cur_cts_q == RMPS_CTS_TXBUF) ? !tx_buf_full : rx_ready; // R8

  // Registered outputs and IO pin drive
  always_ff @(posedge clk) begin
    if (!rstn) begin
      regulators_on_q <= 1'h0;
      running_q       <= 1'h0;
      tx_enable_q     <= 1'h0;
      tx_allow_q      <= 1'h0;
      user_txd_q      <= 1'h0;
      link.rxd        <= 1'h0;
      link.rxd_oe     <= 1'h0;
      link.cts        <= 1'h0;
      link.cts_oe     <= 1'h0;
    end else begin
      regulators_on_q <= en_s; // R2
      running_q       <= run_d;
      tx_enable_q     <= run_d && (cur_radio_q == RMPS_RADIO_TXRX); // R10
      tx_allow_q      <= run_d && ((cur_rts_q == RMPS_RTS_IGNORED) || rts_s); // R8
      user_txd_q      <= run_d & txd_s;
      link.rxd        <= drive_d & user_rxd;
      link.rxd_oe     <= drive_d | (st_d == DEV_FALL && st_q == DEV_RUN); // R6
      link.cts        <= drive_d & cts_val;
      link.cts_oe     <= drive_d | (st_d == DEV_FALL && st_q == DEV_RUN); // R6
    end
  end

endmodule

/* File: hdl/rmps_host.sv */
// Host end: switches supplies and enable in order, keeps IO quiet meanwhile.
// Assumes start and stop pulses from logic on clk; link pins are foreign.
`timescale 1ns/1ps
`include "rmps_regs.svh"
module rmps_host
  import rmps_pkg::*;
#(
  parameter int unsigned IO_DELAY_CYC = 1,
  parameter int unsigned SETTLE_CYC   = `RMPS_IOVS_CYC,
  parameter int unsigned DISCH_CYC    = `RMPS_LDOF_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Link
  rmps_if.host      link,
  // Control
  input  wire logic start,
  input  wire logic stop,
  output logic      ready_q,
  output logic      off_q,
  // Data path
  input  wire logic user_txd,
  input  wire logic user_rts,
  output logic      user_rxd_q,
  output logic      user_cts_q
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;

  // Two flip-flops per pin
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {link.rxd & link.rxd_oe, link.cts & link.cts_oe};
      sync2_q <= sync1_q;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  rmps_hst_st_t st_q;
  rmps_hst_st_t st_d;
  logic [19:0]  cnt_q;
  logic [19:0]  cnt_d;

  // Next sequencer state
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q + 20'h1;
    case (st_q)
      HST_OFF: begin
        cnt_d = 20'h0;
        if (start) begin
          st_d = HST_CHARGE;
        end
      end
      HST_CHARGE: begin
        if (cnt_q >= 20'(`RMPS_VIC_CYC - 1)) begin
          st_d  = HST_IO_START; // R1
          cnt_d = 20'h0;
        end
      end
      HST_IO_START: begin
        if (cnt_q >= 20'(IO_DELAY_CYC - 1) || cnt_q >= 20'(`RMPS_IOEN_CYC - 1)) begin
          st_d  = HST_SETTLE; // R3
          cnt_d = 20'h0;
        end
      end
      HST_SETTLE: begin
        if (cnt_q >= 20'(SETTLE_CYC - 1)) begin
          st_d = HST_READY; // R4
        end
      end
      HST_READY: begin
        cnt_d = 20'h0;
        if (stop) begin
          st_d = HST_QUIET; // R5
        end
      end
      HST_QUIET: begin
        st_d  = HST_DISCHARGE;
        cnt_d = 20'h0;
      end
      HST_DISCHARGE: begin
        if (cnt_q >= 20'(DISCH_CYC - 1)) begin
          st_d = HST_OFF; // R7
        end
      end
      default: begin
        st_d = HST_OFF;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q  <= HST_OFF;
      cnt_q <= 20'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  logic drive_d;
  logic io_d;
  logic en_d;

  // Enable and IO supply stay up one cycle after the IO lines go quiet
  assign drive_d = (st_d == HST_READY); // R4 R5
  assign io_d    = (st_d == HST_SETTLE) || (st_d == HST_READY) || (st_d == HST_QUIET); // R5
  assign en_d    = io_d || (st_d == HST_IO_START);

  // Registered supplies, enable and IO lines
  always_ff @(posedge clk) begin
    if (!rstn) begin
      link.vcc_in_on         <= 1'h0;
      link.module_enable_pin <= 1'h0;
      link.vcc_io_on         <= 1'h0;
      link.txd               <= 1'h0;
      link.txd_oe            <= 1'h0;
      link.rts               <= 1'h0;
      link.rts_oe            <= 1'h0;
      ready_q                <= 1'h0;
      off_q                  <= 1'h1;
      user_rxd_q             <= 1'h0;
      user_cts_q             <= 1'h0;
    end else begin
      link.vcc_in_on         <= (st_d != HST_OFF); // R7
      link.module_enable_pin <= en_d;              // R1 R7
      link.vcc_io_on         <= io_d;              // R3
      link.txd               <= drive_d & user_txd;
      link.txd_oe            <= drive_d;
      link.rts               <= drive_d & user_rts;
      link.rts_oe            <= drive_d;
      ready_q                <= drive_d;
      off_q                  <= (st_d == HST_OFF);
      user_rxd_q             <= drive_d & sync2_q[1];
      user_cts_q             <= drive_d & sync2_q[0];
    end
  end

endmodule

/* File: verif/rmps_assertions.sv */
// Checker for the link between host and module ends.
// Assumes the bench wires it to the rmps_if signals and shared clock.
`timescale 1ns/1ps
module rmps_assertions #(
  parameter int SETTLE_CYC = 20,
  parameter int DISCH_CYC  = 30,
  parameter int FALL_CYC   = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host lines
  input wire logic vcc_in_on,
  input wire logic vcc_io_on,
  input wire logic module_enable_pin,
  input wire logic txd,
  input wire logic txd_oe,
  input wire logic rts,
  input wire logic rts_oe,
  // Module lines
  input wire logic rxd,
  input wire logic rxd_oe,
  input wire logic cts,
  input wire logic cts_oe
);
  // ****************
  // Interval counters
  // ****************
  localparam int VIC_CYC = 2501;
  logic [15:0] low_cnt_q;
  logic [15:0] low_cnt_d;
  logic [15:0] io_cnt_q;
  logic [15:0] io_cnt_d;
  // Cycles of supply with enable low, and of IO supply on
  always_comb begin
    low_cnt_d = (vcc_in_on && !module_enable_pin) ? low_cnt_q + 16'h0001 : 16'h0000;
    io_cnt_d  = vcc_io_on ? io_cnt_q + 16'h0001 : 16'h0000;
  end
  // Counter registers, cleared in reset
  always_ff @(posedge clk) begin
    low_cnt_q <= rstn ? low_cnt_d : 16'h0000;
    io_cnt_q  <= rstn ? io_cnt_d : 16'h0000;
  end
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_charge_wait: assert property ($rose(module_enable_pin) |-> low_cnt_q >= VIC_CYC)
    else $error("enable raised too early");
  chk_regs_up: assert property ($rose(rxd_oe) |-> module_enable_pin && vcc_io_on)
    else $error("module drives while unpowered");
  chk_io_supply: assert property ($rose(module_enable_pin) |-> ##[1:4] vcc_io_on)
    else $error("IO supply late");
  chk_io_settle: assert property ($rose(txd_oe) |-> io_cnt_q >= SETTLE_CYC)
    else $error("host drives before IO settled");
  chk_host_quiet: assert property ((txd_oe || rts_oe) |-> module_enable_pin && vcc_io_on)
    else $error("host drives unpowered module");
  chk_host_zero: assert property ((txd_oe || !txd) && (rts_oe || !rts))
    else $error("undriven host line high");
  chk_quiet_first: assert property ((txd_oe || rts_oe) |=> module_enable_pin)
    else $error("enable dropped while host drives");
  chk_io_free: assert property ($fell(vcc_io_on) |-> ##[1:FALL_CYC] !(rxd_oe || cts_oe))
    else $error("module IO not released");
  chk_module_zero: assert property ((rxd_oe || !rxd) && (cts_oe || !cts))
    else $error("undriven module line high");
  chk_disch_wait: assert property ($fell(vcc_in_on) |-> low_cnt_q >= DISCH_CYC)
    else $error("supply removed too early");
endmodule

/* File: verif/radio_module_power_sequencing_tb.sv */
// Bench joining host and module ends through rmps_if, with the checker.
// Assumes rmps_pkg, rmps_if and both ends are compiled first.
`timescale 1ns/1ps
module radio_module_power_sequencing_tb
  import rmps_pkg::*;
;
  // ****************
  // Signals
  // ****************
  localparam int VIC    = 2501;
  localparam int SETTLE = 20;
  localparam int DISCH  = 30;
  localparam int FALL   = 10;
  logic        clk, rstn, start, stop, user_txd, user_rts, cfg_we, user_rxd;
  logic        rx_ready, tx_buf_full, regs_on, running, tx_en, tx_allow;
  logic        m_txd, ready, off, h_rxd, h_cts;
  logic [15:0] baud_div;
  rmps_cts_t   cfg_cts, cur_cts;
  rmps_rts_t   cfg_rts, cur_rts;
  rmps_err_t   cfg_err, cur_err;
  rmps_radio_t cfg_radio, cur_radio;
  rmps_par_t   cfg_parity, cur_parity;
  rmps_baud_t  cfg_baud, cur_baud;
  int          err_count, checked;
  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // Both ends and the link checker
  rmps_if link_if ();
  rmps_host #(.SETTLE_CYC(SETTLE), .DISCH_CYC(DISCH)) rmps_host_inst (
    .clk(clk), .rstn(rstn), .link(link_if.host), .start(start), .stop(stop),
    .ready_q(ready), .off_q(off), .user_txd(user_txd), .user_rts(user_rts),
    .user_rxd_q(h_rxd), .user_cts_q(h_cts));
  rmps_module #(.FALL_CYC(FALL)) rmps_module_inst (
    .clk(clk), .rstn(rstn), .link(link_if.module_end), .cfg_we(cfg_we), .cfg_cts(cfg_cts),
    .cfg_rts(cfg_rts), .cfg_err(cfg_err), .cfg_radio(cfg_radio), .cfg_parity(cfg_parity),
    .cfg_baud(cfg_baud), .cur_cts_q(cur_cts), .cur_rts_q(cur_rts), .cur_err_q(cur_err),
    .cur_radio_q(cur_radio), .cur_parity_q(cur_parity), .cur_baud_q(cur_baud),
    .baud_div_q(baud_div), .regulators_on_q(regs_on), .running_q(running),
    .tx_enable_q(tx_en), .tx_allow_q(tx_allow), .user_rxd(user_rxd), .rx_ready(rx_ready),
    .tx_buf_full(tx_buf_full), .user_txd_q(m_txd));
  rmps_assertions #(.SETTLE_CYC(SETTLE), .DISCH_CYC(DISCH), .FALL_CYC(FALL))
    rmps_assertions_inst (
    .clk(clk), .rstn(rstn), .vcc_in_on(link_if.vcc_in_on), .vcc_io_on(link_if.vcc_io_on),
    .module_enable_pin(link_if.module_enable_pin), .txd(link_if.txd),
    .txd_oe(link_if.txd_oe), .rts(link_if.rts), .rts_oe(link_if.rts_oe), .rxd(link_if.rxd),
    .rxd_oe(link_if.rxd_oe), .cts(link_if.cts), .cts_oe(link_if.cts_oe));
  // ****************
  // Shared tasks
  // ****************
  // Verdict and end of run
  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d mismatched", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  // Observed level by index
  function automatic logic sig(input int k);
    case (k)
      0: return link_if.vcc_in_on;
      1: return link_if.module_enable_pin;
      2: return link_if.vcc_io_on;
      3: return link_if.txd_oe;
      4: return regs_on;
      5: return link_if.rxd_oe;
      6: return h_rxd;
      7: return h_cts;
      8: return tx_allow;
      default: return m_txd;
    endcase
  endfunction
  // Count cycles until a level shows, bounded
  task automatic wait_for(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (sig(k) !== v) begin
      err_count++;
      $display("FAIL %0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  // Load all settings in one write
  task automatic set_cfg(input rmps_cts_t c, input rmps_rts_t r, input rmps_err_t e,
                         input rmps_radio_t d, input rmps_par_t p, input rmps_baud_t b);
    cfg_cts    = c;
    cfg_rts    = r;
    cfg_err    = e;
    cfg_radio  = d;
    cfg_parity = p;
    cfg_baud   = b;
    cfg_we = 1'b1;
    @(negedge clk);
    cfg_we = 1'b0;
    @(negedge clk);
  endtask
  // ****************
  // Scenarios
  // ****************
  // Delivery defaults after reset
  task automatic t_defaults();
    chk(cur_cts, RMPS_CTS_TXBUF, "cts mode");
    chk(cur_rts, RMPS_RTS_IGNORED, "rts mode");
    chk(cur_err, RMPS_ERR_NONE, "error check");
    chk(cur_radio, RMPS_RADIO_TXRX, "radio state");
    chk(cur_parity, RMPS_PAR_NONE, "parity");
    chk(cur_baud, RMPS_B115200, "rate");
    chk(baud_div, 16'h01b2, "divider");
  endtask
  // Every error check code, other modes, lowest rate, reserved parity
  task automatic t_settings();
    for (int i = 0; i < 4; i++) begin
      set_cfg(RMPS_CTS_CLEAR, RMPS_RTS_FLOW, rmps_err_t'(i), RMPS_RADIO_RX, RMPS_PAR_EVEN,
              RMPS_B1200);
      chk(cur_err, 16'(i), "error check code");
    end
    chk(cur_cts, RMPS_CTS_CLEAR, "cts clear mode");
    chk(cur_rts, RMPS_RTS_FLOW, "rts flow mode");
    chk(cur_radio, RMPS_RADIO_RX, "receive only");
    chk(baud_div, 16'ha2c2, "slow divider");
    set_cfg(RMPS_CTS_TXBUF, RMPS_RTS_FLOW, RMPS_ERR_NONE, RMPS_RADIO_RX, RMPS_PAR_RSVD,
            RMPS_B115200);
    chk(cur_parity, RMPS_PAR_EVEN, "reserved parity");
    chk(baud_div, 16'h01b2, "fast divider");
  endtask
  // Full power-up and traffic both ways
  task automatic t_power_up();
    int n;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    wait_for(0, 1'b1, 4, n);
    wait_for(1, 1'b1, VIC + 4, n);
    chk(16'(n), 16'(VIC), "charge wait");
    wait_for(2, 1'b1, 8, n);
    chk(16'(n), 16'h0001, "IO supply delay");
    wait_for(4, 1'b1, 8, n);
    chk(16'(n), 16'h0002, "regulators on");
    chk(link_if.txd_oe, 1'b0, "host quiet");
    wait_for(3, 1'b1, SETTLE, n);
    chk(16'(n), 16'(SETTLE - 2), "settle wait");
    chk(running, 1'b1, "module running");
    chk(ready, 1'h1, "host ready");
    wait_for(6, 1'b1, 8, n);
    wait_for(9, 1'b1, 8, n);
    chk(tx_en, 1'b0, "transmit off");
    chk(tx_allow, 1'b0, "flow held");
    chk(h_cts, 1'b0, "buffer full");
    user_rts = 1'b1;
    tx_buf_full = 1'b0;
    wait_for(8, 1'b1, 8, n);
    wait_for(7, 1'b1, 8, n);
    chk(h_cts, 1'b1, "buffer free");
    // Other handshake and radio modes while running
    user_rts = 1'h0;
    set_cfg(RMPS_CTS_CLEAR, RMPS_RTS_IGNORED, RMPS_ERR_NONE, RMPS_RADIO_TXRX, RMPS_PAR_ODD,
            RMPS_B115200);
    chk(cur_parity, RMPS_PAR_ODD, "odd parity");
    rx_ready = 1'h0;
    wait_for(7, 1'h0, 8, n);
    chk(16'(n), 16'h0004, "cts follows ready");
    chk(tx_allow, 1'h1, "rts ignored");
    chk(tx_en, 1'h1, "transmit on");
  endtask
  // Shutdown order and release
  task automatic t_power_down();
    int n;
    int m;
    stop = 1'b1;
    @(negedge clk);
    stop = 1'b0;
    wait_for(3, 1'b0, 4, n);
    chk(link_if.module_enable_pin, 1'b1, "enable after quiet");
    chk(ready, 1'h0, "host not ready");
    wait_for(1, 1'b0, 4, n);
    chk(16'(n), 16'h0001, "enable drop");
    wait_for(5, 1'b0, FALL + 1, m);
    chk(16'(m <= FALL), 16'h0001, "IO release");
    wait_for(0, 1'b0, DISCH + 4, n);
    chk(16'(n + m), 16'(DISCH), "discharge wait");
    chk(off, 1'b1, "host off");
    chk(regs_on, 1'h0, "regulators off");
    chk(running, 1'h0, "module stopped");
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    err_count = 0;
    checked = 0;
    {rstn, start, stop, cfg_we, user_rts} = 5'h00;
    {user_txd, user_rxd, rx_ready, tx_buf_full} = 4'hf;
    cfg_cts    = RMPS_CTS_CLEAR;
    cfg_rts    = RMPS_RTS_IGNORED;
    cfg_err    = RMPS_ERR_NONE;
    cfg_radio  = RMPS_RADIO_TXRX;
    cfg_parity = RMPS_PAR_NONE;
    cfg_baud   = RMPS_B1200;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_defaults();
    $display("done: defaults");
    t_settings();
    $display("done: settings");
    t_power_up();
    $display("done: power up");
    t_power_down();
    $display("done: power down");
    report_and_stop();
  end
endmodule
